/* File: common/prl_pkg.sv */
// Package for the peripheral signal routing register bank
package prl_pkg;

	// Counts of selector registers and selector field width
	localparam int unsigned NUM_IN       = 18;
	localparam int unsigned NUM_OUT_A    = 5;
	localparam int unsigned NUM_OUT_C    = 6;
	localparam int unsigned NUM_OUT      = NUM_OUT_A + NUM_OUT_C;
	localparam int unsigned SEL_W        = 5;

	// Byte offsets: lock, then input selectors, then output selectors, then config, one word each
	localparam logic [11:0] OFF_LOCK     = 12'h000;
	localparam logic [11:0] OFF_IN_BASE  = 12'h040;
	localparam logic [11:0] OFF_OUT_BASE = 12'h0c0;
	localparam logic [11:0] OFF_CFG      = 12'h100;

	// Lock register fields and unlock keys
	localparam int unsigned LOCK_BIT     = 0;
	localparam logic [7:0]  LOCK_RESET   = 8'h00;
	localparam logic [7:0]  KEY_FIRST    = 8'h55;
	localparam logic [7:0]  KEY_SECOND   = 8'haa;

	// Selector reset values
	localparam logic [SEL_W-1:0] OUT_SEL_RESET = 5'h00;
	localparam logic [SEL_W-1:0] IN_SEL_RESET  = 5'h00;

	// AHB encodings
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	// Unlock sequence states
	typedef enum logic [1:0] {
		KEY_IDLE  = 2'b00,
		KEY_GOT55 = 2'b01,
		KEY_OPEN  = 2'b10
	} prl_key_t;

	// Captured address phase of a bus transfer
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
	} prl_aphase_t;

endpackage : prl_pkg

/* File: rtl/prl_route_regs.sv */
// Register bank of the peripheral signal routing unit on an AHB-Lite slave
`timescale 1ns/1ps
// Notes on behaviour
// - Lock flag set freezes every input and output selector against writes.
// - Lock flag clear lets software writes change any selector.
// - Lock register bits 7..1 read zero; writes to them are not stored, though the whole byte is matched against the unlock keys.
// - Lock flag is read/write and clears at every reset.
// - Eighteen 8-bit input selectors, source in bits 4..0, bits 7..5 zero.
// - Output selectors for port A pins 0,1,2,4,5; port C 0..5 only large variant.
// - With one-shot option, flag may be cleared only once per reset; it may be set again once after that clear, then stays set.
// - All routing registers read back at any time.
// - Power-on reset restores selectors and clears flag; others keep selectors.
module prl_route_regs
	import prl_pkg::*;
#(
	parameter bit HAS_PORT_C = 1'b1
) (
	// Clock and resets
	input  wire logic                         clock,
	input  wire logic                         resetn,
	input  wire logic                         por_resetn,
	// Configuration option
	input  wire logic                         one_shot_lock_option,
	// AHB-Lite slave
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic      [31:0]                  hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	// Selector fields toward the routing multiplexers
	output logic      [NUM_IN-1:0][SEL_W-1:0] in_sel,
	output logic      [NUM_OUT-1:0][SEL_W-1:0] out_sel,
	output logic                              route_lock_flag
);

	// Address decode helper used for both selector banks
	// Addresses a full 256-byte span or more past the base give an out-of-range index, so they cannot alias
	function automatic logic [5:0] word_index(input logic [11:0] addr, input logic [11:0] base);
		logic [11:0] diff;
		diff = addr - base;
		if (diff[11:8] != 4'h0) begin
			return 6'h3f;
		end
		return diff[7:2];
	endfunction : word_index

	// Address phase capture
	prl_aphase_t ap_q, ap_d;
	logic [31:0] rdata_q, rdata_d;

	always_comb begin
		ap_d = '0;
		if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ) && hsize == HSIZE_WORD) begin
			ap_d.valid = 1'b1;
			ap_d.write = hwrite;
			ap_d.addr  = {haddr[11:2], 2'b00};
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ap_q <= '0;
		end else begin
			ap_q <= ap_d;
		end
	end

	// Decode of the data-phase write
	logic       wr_lock;
	logic       wr_cfg;
	logic       wr_in_hit;
	logic       wr_out_hit;
	logic [5:0] in_idx;
	logic [5:0] out_idx;
	logic [7:0] wbyte;

	always_comb begin
		wbyte      = hwdata[7:0];
		in_idx     = word_index(ap_q.addr, OFF_IN_BASE);
		out_idx    = word_index(ap_q.addr, OFF_OUT_BASE);
		wr_lock    = ap_q.valid && ap_q.write && ap_q.addr == OFF_LOCK;
		wr_cfg     = ap_q.valid && ap_q.write && ap_q.addr == OFF_CFG;
		wr_in_hit  = ap_q.valid && ap_q.write && ap_q.addr >= OFF_IN_BASE
			&& in_idx < 6'(NUM_IN);
		wr_out_hit = ap_q.valid && ap_q.write && ap_q.addr >= OFF_OUT_BASE
			&& out_idx < 6'(HAS_PORT_C ? NUM_OUT : NUM_OUT_A);
	end

	// Unlock key sequence and lock flag; every reset clears these
	prl_key_t key_q, key_d;
	logic     lock_q, lock_d;
	logic     used_q, used_d;         // One-shot option: a clear has been spent

	always_comb begin
		key_d  = key_q;
		lock_d = lock_q;
		used_d = used_q;
		if (ap_q.valid && ap_q.write) begin
			// Any bus write outside the keys breaks the sequence
			key_d = KEY_IDLE;
			if (wr_lock) begin
				case (key_q)
					KEY_IDLE: begin
						if (wbyte == KEY_FIRST) key_d = KEY_GOT55;
					end
					KEY_GOT55: begin
						if (wbyte == KEY_SECOND) key_d = KEY_OPEN;
						else if (wbyte == KEY_FIRST) key_d = KEY_GOT55;
					end
					KEY_OPEN: begin
						// Only bit 0 is stored; upper bits dropped
						if (wbyte[LOCK_BIT] != lock_q) begin
							if (!wbyte[LOCK_BIT]) begin
								if (!(one_shot_lock_option && used_q)) begin
									lock_d = 1'b0;
									used_d = 1'b1;
								end
							end else begin
								lock_d = 1'b1;
							end
						end
					end
					default: key_d = KEY_IDLE;
				endcase
			end
			// Writes outside KEY_OPEN leave the flag alone
		end
		// One-shot: a second set after the spent clear is still allowed; after that no more clear
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			key_q  <= KEY_IDLE;
			lock_q <= LOCK_RESET[LOCK_BIT];
			used_q <= 1'b0;
		end else begin
			key_q  <= key_d;
			lock_q <= lock_d;
			used_q <= used_d;
		end
	end

	// Selectors survive system resets; only power-on reset restores them
	logic [NUM_IN-1:0][SEL_W-1:0]  in_q, in_d;
	logic [NUM_OUT-1:0][SEL_W-1:0] out_q, out_d;

	always_comb begin
		in_d  = in_q;
		out_d = out_q;
		if (!lock_q) begin
			if (wr_in_hit) in_d[in_idx[4:0]] = wbyte[SEL_W-1:0];
			if (wr_out_hit) out_d[out_idx[3:0]] = wbyte[SEL_W-1:0];
		end
	end

	always_ff @(posedge clock or negedge por_resetn) begin
		if (!por_resetn) begin
			in_q  <= {NUM_IN{IN_SEL_RESET}};
			out_q <= {NUM_OUT{OUT_SEL_RESET}};
		end else begin
			in_q  <= in_d;
			out_q <= out_d;
		end
	end

	// Read data prepared in the address phase so it stands in the data phase
	always_comb begin
		logic [5:0] ri;
		logic [5:0] ro;
		logic [11:0] ra;
		ra      = {haddr[11:2], 2'b00};
		ri      = word_index(ra, OFF_IN_BASE);
		ro      = word_index(ra, OFF_OUT_BASE);
		rdata_d = 32'h0000_0000;
		if (ap_d.valid && !ap_d.write) begin
			if (ra == OFF_LOCK) begin
				rdata_d = {31'h0000_0000, lock_d};
			end else if (ra == OFF_CFG) begin
				rdata_d = {30'h0000_0000, used_d, one_shot_lock_option};
			end else if (ra >= OFF_IN_BASE && ri < 6'(NUM_IN)) begin
				rdata_d = {27'h000_0000, in_d[ri[4:0]]};
			end else if (ra >= OFF_OUT_BASE && ro < 6'(HAS_PORT_C ? NUM_OUT : NUM_OUT_A)) begin
				rdata_d = {27'h000_0000, out_d[ro[3:0]]};
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs: zero-wait slave, always OKAY
	assign hrdata          = rdata_q;
	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign in_sel          = in_q;
	assign out_sel         = out_q;
	assign route_lock_flag = lock_q;

endmodule : prl_route_regs

/* File: sim/prl_route_regs_props.sv */
// Assertion checker for the routing register bank
`timescale 1ns/1ps
module prl_route_regs_props
	import prl_pkg::*;
(
	// Clock, resets and option
	input wire logic clock, resetn, por_resetn, one_shot_lock_option,
	// Bus
	input wire logic hsel, hwrite, hready, hreadyout, hresp,
	input wire logic [31:0] haddr, hwdata, hrdata,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	// Selectors and flag
	input wire logic [NUM_IN-1:0][SEL_W-1:0] in_sel,
	input wire logic [NUM_OUT-1:0][SEL_W-1:0] out_sel,
	input wire logic route_lock_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	logic tk, wr_q, rd_q, rdl_q, rdu_q, fl_q, spent_q;
	// Accepted address phase; its data phase is the next cycle
	assign tk = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{wr_q, rd_q, rdl_q, rdu_q, fl_q, spent_q} <= '0;
		end else begin
			wr_q <= tk & hwrite;
			rd_q <= tk & ~hwrite;
			rdl_q <= tk & ~hwrite & (haddr[11:0] == OFF_LOCK);
			rdu_q <= tk & ~hwrite & (haddr[11:0] > OFF_CFG);
			fl_q <= route_lock_flag;
			spent_q <= spent_q | (fl_q & ~route_lock_flag & one_shot_lock_option);
		end
	end
	chk_ready_okay:
		assert property (hreadyout && !hresp) else $error("bus stalled or errored");
	chk_lock_freeze:
		assert property (route_lock_flag |-> $stable(in_sel) && $stable(out_sel)) else $error("selector moved");
	chk_write_cause:
		assert property ($changed(in_sel) || $changed(out_sel) |-> $past(wr_q)) else $error("selector moved alone");
	chk_flag_cause:
		assert property ($changed(route_lock_flag) |-> $past(wr_q) && $past(hwdata[0]) == route_lock_flag)
			else $error("flag moved");
	chk_lock_read:
		assert property (rdl_q |-> hrdata == {31'h0, route_lock_flag}) else $error("lock read wrong");
	chk_read_width:
		assert property (rd_q |-> hrdata[31:5] == 27'h0) else $error("read high bits set");
	chk_unmapped_zero:
		assert property (rdu_q |-> hrdata == 32'h0) else $error("unmapped read not zero");
	chk_one_clear:
		assert property (spent_q && one_shot_lock_option |-> !$fell(route_lock_flag)) else $error("second clear");
endmodule : prl_route_regs_props
bind prl_route_regs prl_route_regs_props u_props (.clock, .resetn, .por_resetn, .one_shot_lock_option, .hsel,
	.hwrite, .hready, .hreadyout, .hresp, .haddr, .hwdata, .hrdata, .htrans, .hsize, .in_sel, .out_sel,
	.route_lock_flag);

/* File: sim/prl_route_regs_bench.sv */
// Self-checking bench for the routing register bank
`timescale 1ns/1ps
module prl_route_regs_bench;
	import prl_pkg::*;
	logic clock, resetn, por_resetn, one_shot_lock_option, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [NUM_IN-1:0][SEL_W-1:0] in_sel;
	logic [NUM_OUT-1:0][SEL_W-1:0] out_sel;
	logic route_lock_flag;
	int errors, checks;
	assign hready = hreadyout; // Only slave on the bus
	prl_route_regs uut (.clock, .resetn, .por_resetn, .one_shot_lock_option, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .in_sel, .out_sel, .route_lock_flag);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Single transfer; read data taken at the edge that closes the data phase
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		haddr <= {20'h00000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		r = hrdata;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, exp, $sformatf("reg %h", a));
	endtask : rd
	task automatic key(input logic [31:0] v);
		wr(OFF_LOCK, 32'(KEY_FIRST));
		wr(OFF_LOCK, 32'(KEY_SECOND));
		wr(OFF_LOCK, v);
	endtask : key
	// Power-on reset also pulls the system reset, as the bank expects
	task automatic rst(input logic por);
		resetn <= 1'b0;
		por_resetn <= ~por;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		por_resetn <= 1'b1;
		@(posedge clock);
	endtask : rst
	task automatic final_report;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	initial begin
		{resetn, por_resetn, one_shot_lock_option, hsel, hwrite, htrans} = '0;
		{haddr, hwdata} = '0;
		hsize = HSIZE_WORD;
		errors = 0;
		checks = 0;
		@(posedge clock);
		hsel <= 1'b1;
		rst(1'b1);
		rd(OFF_LOCK, 32'h0);
		// High bits written as ones to show they are dropped
		for (int i = 0; i < NUM_IN; i++) wr(OFF_IN_BASE + 12'(4 * i), 32'hffffffe0 | 32'(i));
		for (int j = 0; j < NUM_OUT; j++) wr(OFF_OUT_BASE + 12'(4 * j), 32'hffffffe0 | 32'(31 - j));
		for (int i = 0; i < NUM_IN; i++) rd(OFF_IN_BASE + 12'(4 * i), 32'(i));
		for (int j = 0; j < NUM_OUT; j++) rd(OFF_OUT_BASE + 12'(4 * j), 32'(31 - j));
		for (int i = 0; i < NUM_IN; i++) chk(32'(in_sel[i]), 32'(i), "in_sel port");
		for (int j = 0; j < NUM_OUT; j++) chk(32'(out_sel[j]), 32'(31 - j), "out_sel port");
		wr(OFF_LOCK, 32'h1);
		rd(OFF_LOCK, 32'h0);
		key(32'hff);
		rd(OFF_LOCK, 32'h1);
		wr(OFF_OUT_BASE, 32'h5);
		wr(OFF_IN_BASE, 32'h5);
		rd(OFF_OUT_BASE, 32'h1f);
		rd(OFF_IN_BASE, 32'h0);
		key(32'h0);
		wr(OFF_IN_BASE, 32'h5);
		rd(OFF_IN_BASE, 32'h5);
		wr(12'h200, 32'h1f);
		rd(12'h200, 32'h0);
		rst(1'b0);
		rd(OFF_IN_BASE, 32'h5);
		rd(OFF_LOCK, 32'h0);
		one_shot_lock_option <= 1'b1;
		key(32'h1);
		key(32'h0);
		rd(OFF_LOCK, 32'h0);
		key(32'h1);
		key(32'h0);
		rd(OFF_LOCK, 32'h1);
		chk(32'(route_lock_flag), 32'h1, "lock flag port");
		rd(OFF_CFG, 32'h3);
		rst(1'b1);
		rd(OFF_IN_BASE, 32'h0);
		rd(OFF_OUT_BASE, 32'h0);
		final_report();
	end
	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		final_report();
	end
endmodule : prl_route_regs_bench
